// *** include/can_buf_pkg.sv ***
// Shared constants for the CAN message buffer host port
package can_buf_pkg;
  // ---------------------------------------------------------------
  // Message object and queue sizes
  // ---------------------------------------------------------------
  localparam int MSG_ELEMENTS = 11;
  localparam int DATA_BYTES   = 8;
  localparam int ID_W         = 29;
  localparam int ID_STD_W     = 11;
  localparam int STAMP_W      = 16;
  localparam int LEN_W        = 4;
  localparam int RX_DEPTH     = 64;
  localparam int TX_DEPTH     = 8;
  localparam int NUM_FILTERS  = 4;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_DATA     = 8'h00;
  localparam logic [7:0] OFF_LEN      = 8'h20;
  localparam logic [7:0] OFF_ID       = 8'h24;
  localparam logic [7:0] OFF_STAMP    = 8'h28;
  localparam logic [7:0] OFF_INIT     = 8'h2C;
  localparam logic [7:0] OFF_FETCH    = 8'h30;
  localparam logic [7:0] OFF_TX       = 8'h34;
  localparam logic [7:0] OFF_FLT_ID   = 8'h38;
  localparam logic [7:0] OFF_FLT_CTRL = 8'h3C;
  localparam logic [7:0] OFF_RESULT   = 8'h40;
  localparam logic [7:0] OFF_STATUS   = 8'h44;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h48;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h4C;
  localparam int         DATA_IDX_LSB = 2;
  localparam int         DATA_IDX_MSB = 4;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TX_PRIO_BIT  = 0;
  localparam int TX_LONG_BIT  = 1;
  localparam int FLT_NO_LSB   = 0;
  localparam int FLT_NO_MSB   = 1;
  localparam int FLT_EN_BIT   = 2;
  localparam int FLT_LONG_BIT = 3;
  localparam int IRQ_RX       = 0;
  localparam int IRQ_TX       = 1;
  localparam int IRQ_INIT     = 2;
  localparam int IRQ_W        = 3;
  // ---------------------------------------------------------------
  // Result codes, limits, reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] RES_OK      = 32'h0000_0000;
  localparam logic [31:0] RES_FAIL    = 32'hFFFF_FFFF;
  localparam logic [31:0] RES_BAD     = 32'h0000_0001;
  localparam logic [31:0] BAUD_MIN    = 32'h0000_1388;
  localparam logic [31:0] BAUD_MAX    = 32'h000F_4240;
  localparam logic [31:0] BAUD_RESET  = 32'h0000_0000;
  localparam logic [3:0]  LEN_MAX     = 4'h8;
endpackage : can_buf_pkg

// *** rtl/can_msg_buffer.sv ***
// CAN message buffer: message object, receive queue, filters, transmit queue
//
// Operation
// RL1: Eleven elements; elements one to eight hold data
// RL2: Element nine holds data byte count, zero to eight
// RL3: Element ten holds 11-bit or 29-bit identifier
// RL4: Reception stores 16-bit time stamp in element eleven
// RL5: Time stamp ignored when accepting a transmission
// RL6: Init resets controller, flushes queues, disables filters, sets baud
// RL7: Init result: minus one absent, zero ok, one bad
// RL8: Host initialises before any other operation
// RL9: Fetch: minus one if empty, else oldest plus identifier
// RL10: Each received message delivered once, then removed
// RL11: 64-deep receive queue overwrites oldest silently
// RL12: Four filters; any enabled match stores message
// RL13: Length select zero means 11-bit, one 29-bit
// RL14: Filter setup returns zero ok, nonzero on failure
// RL15: Priority zero queues; priority one sends next
// RL16: High priority overtakes; normal ones keep order
// RL17: Transmit returns zero accepted, minus one when full
// RL18: Sending starts only after bus access is won
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module can_msg_buffer #(
  parameter bit IFACE_PRESENT = 1'b1,
  parameter int RX_DEPTH      = can_buf_pkg::RX_DEPTH,
  parameter int TX_DEPTH      = can_buf_pkg::TX_DEPTH,
  parameter int NUM_FILTERS   = can_buf_pkg::NUM_FILTERS
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_rx_valid,
  input  wire logic        i_rx_long,
  input  wire logic [28:0] i_rx_id,
  input  wire logic [3:0]  i_rx_len,
  input  wire logic [63:0] i_rx_data,
  output logic             o_tx_valid,
  output logic             o_tx_long,
  output logic      [28:0] o_tx_id,
  output logic      [3:0]  o_tx_len,
  output logic      [63:0] o_tx_data,
  input  wire logic        i_tx_won,
  output logic             o_ctrl_reset,
  output logic      [31:0] o_baud_rate,
  output logic             o_irq
);
  localparam int RXA  = $clog2(RX_DEPTH);
  localparam int TXA  = $clog2(TX_DEPTH);
  localparam int DATA_W = 8 * can_buf_pkg::DATA_BYTES;
  localparam int TXE_W = 1 + can_buf_pkg::ID_W + can_buf_pkg::LEN_W + DATA_W;
  localparam int RXE_W = can_buf_pkg::STAMP_W + can_buf_pkg::ID_W + can_buf_pkg::LEN_W + DATA_W;
  localparam logic [RXA:0] RX_FULL = (RXA+1)'(RX_DEPTH);
  localparam logic [TXA:0] TX_FULL = (TXA+1)'(TX_DEPTH);

  function automatic logic id_fits(input logic [28:0] id, input logic long_sel);
    id_fits = long_sel || (id >> can_buf_pkg::ID_STD_W) == '0;
  endfunction : id_fits

  // ---------------------------------------------------------------
  // Bus slave: one wait state, writes act at the completing edge
  // ---------------------------------------------------------------
  logic [31:0] prdata_nxt;
  logic        pslverr_nxt;
  logic        wr_fire, rd_fire;
  logic [7:0]  msg_data_r [can_buf_pkg::DATA_BYTES];
  logic [3:0]  msg_len_r;
  logic [28:0] msg_id_r;
  logic [15:0] msg_stamp_r;
  logic [15:0] stamp_r;
  logic [31:0] result_r;
  logic        init_done_r;
  logic [can_buf_pkg::IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_evt;
  logic [28:0] flt_id_stage_r;
  logic        flt_en_r   [NUM_FILTERS];
  logic        flt_long_r [NUM_FILTERS];
  logic [28:0] flt_id_r   [NUM_FILTERS];
  logic [RXE_W-1:0] rx_mem [RX_DEPTH];
  logic [RXA-1:0]   rx_wr_r, rx_rd_r;
  logic [RXA:0]     rx_cnt_r;
  logic [TXE_W-1:0] tx_mem [TX_DEPTH];
  logic [TXE_W-1:0] hp_r;
  logic [TXA-1:0]   tx_wr_r, tx_rd_r;
  logic [TXA:0]     tx_cnt_r;
  logic             hp_full_r, tx_from_hp_r;

  assign wr_fire = i_psel && i_penable && o_pready && i_pwrite;
  assign rd_fire = i_psel && i_penable && o_pready && !i_pwrite;

  always_comb begin
    prdata_nxt  = '0;
    pslverr_nxt = 1'b0;
    if (i_paddr[1:0] != 2'h0) begin
      pslverr_nxt = 1'b1;
    end else if (i_paddr < can_buf_pkg::OFF_LEN) begin
      prdata_nxt = 32'(msg_data_r[i_paddr[can_buf_pkg::DATA_IDX_MSB:can_buf_pkg::DATA_IDX_LSB]]);
    end else begin
      case (i_paddr)
        can_buf_pkg::OFF_LEN:      prdata_nxt = 32'(msg_len_r);
        can_buf_pkg::OFF_ID:       prdata_nxt = 32'(msg_id_r);
        can_buf_pkg::OFF_STAMP:    prdata_nxt = 32'(msg_stamp_r);
        can_buf_pkg::OFF_INIT:     prdata_nxt = o_baud_rate;
        can_buf_pkg::OFF_FETCH:    prdata_nxt = '0;
        can_buf_pkg::OFF_TX:       prdata_nxt = '0;
        can_buf_pkg::OFF_FLT_ID:   prdata_nxt = 32'(flt_id_stage_r);
        can_buf_pkg::OFF_FLT_CTRL: prdata_nxt = '0;
        can_buf_pkg::OFF_RESULT:   prdata_nxt = result_r;
        can_buf_pkg::OFF_STATUS:   prdata_nxt = 32'({rx_cnt_r, tx_cnt_r, hp_full_r, init_done_r});
        can_buf_pkg::OFF_IRQ_STAT: prdata_nxt = 32'(irq_stat_r);
        can_buf_pkg::OFF_IRQ_MASK: prdata_nxt = 32'(irq_mask_r);
        default:                   pslverr_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel && i_penable && !o_pready;
      o_pslverr <= i_psel && i_penable && !o_pready && pslverr_nxt;
      o_prdata  <= (i_psel && i_penable && !o_pready && !i_pwrite) ? prdata_nxt : '0;
    end
  end

  // ---------------------------------------------------------------
  // Commands
  // ---------------------------------------------------------------
  logic init_go, fetch_go, tx_go, flt_go, baud_ok, tx_prio, tx_accept, flt_ok;
  logic [1:0] flt_no;
  assign init_go   = wr_fire && i_paddr == can_buf_pkg::OFF_INIT;
  assign fetch_go  = wr_fire && i_paddr == can_buf_pkg::OFF_FETCH;
  assign tx_go     = wr_fire && i_paddr == can_buf_pkg::OFF_TX;
  assign flt_go    = wr_fire && i_paddr == can_buf_pkg::OFF_FLT_CTRL;
  assign baud_ok   = i_pwdata >= can_buf_pkg::BAUD_MIN && i_pwdata <= can_buf_pkg::BAUD_MAX;
  assign tx_prio   = i_pwdata[can_buf_pkg::TX_PRIO_BIT];
  assign flt_no    = i_pwdata[can_buf_pkg::FLT_NO_MSB:can_buf_pkg::FLT_NO_LSB];
  // Operations before init are refused rather than acting on stale state
  assign tx_accept = IFACE_PRESENT && init_done_r &&                          // RL8
                     (tx_prio ? !hp_full_r : tx_cnt_r != TX_FULL);            // RL17
  assign flt_ok    = IFACE_PRESENT && init_done_r && 32'(flt_no) < NUM_FILTERS &&
                     id_fits(flt_id_stage_r, i_pwdata[can_buf_pkg::FLT_LONG_BIT]); // RL14

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      result_r     <= can_buf_pkg::RES_OK;
      init_done_r  <= 1'b0;
      o_baud_rate  <= can_buf_pkg::BAUD_RESET;
      o_ctrl_reset <= 1'b0;
    end else begin
      o_ctrl_reset <= init_go && IFACE_PRESENT;                               // RL6
      if (init_go) begin
        if (!IFACE_PRESENT) begin
          result_r <= can_buf_pkg::RES_FAIL;                                  // RL7
        end else begin
          init_done_r <= 1'b1;
          result_r    <= baud_ok ? can_buf_pkg::RES_OK : can_buf_pkg::RES_BAD; // RL7
          if (baud_ok) begin
            o_baud_rate <= i_pwdata;                                          // RL6
          end
        end
      end else if (fetch_go) begin
        result_r <= (IFACE_PRESENT && init_done_r && rx_cnt_r != '0) ?
                    32'(rx_mem[rx_rd_r][DATA_W+can_buf_pkg::LEN_W +: can_buf_pkg::ID_W]) :
                    can_buf_pkg::RES_FAIL;                                    // RL9
      end else if (tx_go) begin
        result_r <= tx_accept ? can_buf_pkg::RES_OK : can_buf_pkg::RES_FAIL;  // RL17
      end else if (flt_go) begin
        result_r <= flt_ok ? can_buf_pkg::RES_OK : can_buf_pkg::RES_BAD;     // RL14
      end
    end
  end

  // ---------------------------------------------------------------
  // Message object
  // ---------------------------------------------------------------
  logic rx_pop;
  assign rx_pop = fetch_go && IFACE_PRESENT && init_done_r && rx_cnt_r != '0;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      msg_len_r   <= '0;
      msg_id_r    <= '0;
      msg_stamp_r <= '0;
      for (int i = 0; i < can_buf_pkg::DATA_BYTES; i++) begin
        msg_data_r[i] <= '0;
      end
    end else if (rx_pop) begin
      {msg_stamp_r, msg_id_r, msg_len_r} <= rx_mem[rx_rd_r][RXE_W-1:DATA_W];  // RL4
      for (int i = 0; i < can_buf_pkg::DATA_BYTES; i++) begin
        msg_data_r[i] <= rx_mem[rx_rd_r][8*i +: 8];                           // RL1
      end
    end else if (wr_fire) begin
      if (i_paddr < can_buf_pkg::OFF_LEN && i_paddr[1:0] == 2'h0) begin
        msg_data_r[i_paddr[can_buf_pkg::DATA_IDX_MSB:can_buf_pkg::DATA_IDX_LSB]] <= i_pwdata[7:0];
      end
      if (i_paddr == can_buf_pkg::OFF_LEN) begin
        // Counts written above eight saturate; a fetched length above eight is kept and can be sent
        msg_len_r <= (i_pwdata > 32'(can_buf_pkg::LEN_MAX)) ?
                     can_buf_pkg::LEN_MAX : i_pwdata[3:0];                    // RL2
      end
      if (i_paddr == can_buf_pkg::OFF_ID) begin
        msg_id_r <= i_pwdata[28:0];                                           // RL3
      end
    end
  end

  // ---------------------------------------------------------------
  // Filters and receive queue
  // ---------------------------------------------------------------
  logic rx_hit, rx_push, flush;
  assign flush = init_go && IFACE_PRESENT;

  always_comb begin
    rx_hit = 1'b0;
    for (int f = 0; f < NUM_FILTERS; f++) begin
      if (flt_en_r[f] && flt_long_r[f] == i_rx_long && flt_id_r[f] == i_rx_id) begin
        rx_hit = 1'b1;                                                        // RL12 RL13
      end
    end
  end
  assign rx_push = i_rx_valid && rx_hit && !flush;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      stamp_r        <= '0;
      flt_id_stage_r <= '0;
    end else begin
      stamp_r <= stamp_r + 16'h0001;
      if (wr_fire && i_paddr == can_buf_pkg::OFF_FLT_ID) begin
        flt_id_stage_r <= i_pwdata[28:0];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst || flush) begin
      for (int f = 0; f < NUM_FILTERS; f++) begin
        flt_en_r[f]   <= 1'b0;                                                // RL6
        flt_long_r[f] <= 1'b0;
        flt_id_r[f]   <= '0;
      end
    end else if (flt_go && flt_ok) begin
      flt_en_r[flt_no]   <= i_pwdata[can_buf_pkg::FLT_EN_BIT];
      flt_long_r[flt_no] <= i_pwdata[can_buf_pkg::FLT_LONG_BIT];             // RL13
      flt_id_r[flt_no]   <= flt_id_stage_r;
    end
  end

  always_ff @(posedge i_clock) begin
    if (rx_push) begin
      rx_mem[rx_wr_r] <= {stamp_r, i_rx_id, i_rx_len, i_rx_data};            // RL4
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst || flush) begin
      rx_wr_r  <= '0;
      rx_rd_r  <= '0;
      rx_cnt_r <= '0;                                                         // RL6
    end else begin
      // Full queue: a new message pushes the oldest out, nothing flags it
      if (rx_push) begin
        rx_wr_r <= rx_wr_r + 1'b1;
      end
      if (rx_pop || (rx_push && rx_cnt_r == RX_FULL)) begin
        rx_rd_r <= rx_rd_r + 1'b1;                                            // RL10 RL11
      end
      if (rx_push && !rx_pop && rx_cnt_r != RX_FULL) begin
        rx_cnt_r <= rx_cnt_r + 1'b1;
      end else if (rx_pop && !rx_push) begin
        rx_cnt_r <= rx_cnt_r - 1'b1;                                          // RL10
      end
    end
  end

  // ---------------------------------------------------------------
  // Transmit queue, priority slot and presentation to the bus
  // ---------------------------------------------------------------
  logic [TXE_W-1:0] tx_entry;
  logic [63:0]      msg_flat;
  logic             tx_push, consume;
  always_comb begin
    for (int i = 0; i < can_buf_pkg::DATA_BYTES; i++) begin
      msg_flat[8*i +: 8] = msg_data_r[i];
    end
  end
  // Time stamp deliberately left out of the queued entry
  assign tx_entry = {i_pwdata[can_buf_pkg::TX_LONG_BIT], msg_id_r, msg_len_r, msg_flat}; // RL5
  assign tx_push  = tx_go && tx_accept && !tx_prio;                           // RL15
  assign consume  = o_tx_valid && i_tx_won;                                   // RL18

  always_ff @(posedge i_clock) begin
    if (tx_push) begin
      tx_mem[tx_wr_r] <= tx_entry;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst || flush) begin
      tx_wr_r   <= '0;
      tx_rd_r   <= '0;
      tx_cnt_r  <= '0;
      hp_full_r <= 1'b0;
      hp_r      <= '0;
    end else begin
      if (tx_go && tx_accept && tx_prio) begin
        hp_full_r <= 1'b1;                                                    // RL15
        hp_r      <= tx_entry;
      end else if (consume && tx_from_hp_r) begin
        hp_full_r <= 1'b0;
      end
      if (tx_push) begin
        tx_wr_r <= tx_wr_r + 1'b1;
      end
      if (consume && !tx_from_hp_r) begin
        tx_rd_r <= tx_rd_r + 1'b1;                                            // RL16
      end
      tx_cnt_r <= tx_cnt_r + (TXA+1)'(tx_push) - (TXA+1)'(consume && !tx_from_hp_r);
    end
  end

  // Offer drops for a cycle after each win so the next pick sees fresh state
  always_ff @(posedge i_clock) begin
    if (i_rst || flush || consume) begin
      o_tx_valid   <= 1'b0;
      tx_from_hp_r <= 1'b0;
      {o_tx_long, o_tx_id, o_tx_len, o_tx_data} <= '0;
    end else if (hp_full_r) begin
      o_tx_valid   <= 1'b1;                                                   // RL16
      tx_from_hp_r <= 1'b1;
      {o_tx_long, o_tx_id, o_tx_len, o_tx_data} <= hp_r;
    end else begin
      o_tx_valid   <= tx_cnt_r != '0;
      tx_from_hp_r <= 1'b0;
      {o_tx_long, o_tx_id, o_tx_len, o_tx_data} <= tx_mem[tx_rd_r];
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  assign irq_evt = {flush, consume, rx_push};
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      o_irq      <= 1'b0;
    end else begin
      // Set wins over a simultaneous write-one clear
      irq_stat_r <= (irq_stat_r & ~((wr_fire && i_paddr == can_buf_pkg::OFF_IRQ_STAT) ?
                    i_pwdata[can_buf_pkg::IRQ_W-1:0] : '0)) | irq_evt;
      if (wr_fire && i_paddr == can_buf_pkg::OFF_IRQ_MASK) begin
        irq_mask_r <= i_pwdata[can_buf_pkg::IRQ_W-1:0];
      end
      o_irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_init;
    init_go && IFACE_PRESENT;
  endsequence
  sequence s_flushed;
    rx_cnt_r == '0 && tx_cnt_r == '0 && !hp_full_r && !o_tx_valid && o_ctrl_reset;
  endsequence

  a_init_flush: assert property (s_init |=> s_flushed) else $error("init left state"); // RL6
  a_init_result: assert property (init_go && IFACE_PRESENT && !baud_ok |=>
    result_r == can_buf_pkg::RES_BAD && init_done_r) else $error("bad baud result"); // RL7
  a_rx_empty_fail: assert property (fetch_go && rx_cnt_r == '0 |=>
    result_r == can_buf_pkg::RES_FAIL) else $error("empty fetch result"); // RL9
  a_rx_pop_once: assert property (rx_pop && !rx_push |=>
    rx_cnt_r == $past(rx_cnt_r) - 1'b1) else $error("fetch did not remove"); // RL10
  a_rx_overwrite: assert property (rx_push && rx_cnt_r == RX_FULL && !rx_pop |=>
    rx_cnt_r == RX_FULL && rx_rd_r == $past(rx_rd_r) + 1'b1) else $error("overwrite"); // RL11
  a_rx_filtered: assert property (i_rx_valid && !rx_hit && !flush |=>
    rx_cnt_r == $past(rx_cnt_r) || $past(fetch_go)) else $error("unfiltered store"); // RL12
  a_flt_range: assert property (flt_go && init_done_r &&
    !i_pwdata[can_buf_pkg::FLT_LONG_BIT] && !id_fits(flt_id_stage_r, 1'b0) |=>
    result_r != can_buf_pkg::RES_OK) else $error("short id range"); // RL13 RL14
  a_tx_full_fail: assert property (tx_go && !tx_prio && tx_cnt_r == TX_FULL |=>
    result_r == can_buf_pkg::RES_FAIL) else $error("full queue accepted"); // RL17
  a_hp_first: assert property (hp_full_r && !consume && !init_go |=>
    o_tx_valid && tx_from_hp_r) else $error("priority not next"); // RL16
  a_tx_won_only: assert property (o_tx_valid && !i_tx_won && !init_go && !hp_full_r |=>
    o_tx_valid && tx_cnt_r == $past(tx_cnt_r) + (TXA+1)'($past(tx_push)))
    else $error("queue moved without win"); // RL18
endmodule : can_msg_buffer

// *** tb/can_core_model.sv ***
// Stand-in for the CAN core: frame injector and arbitration grant
`timescale 1ns/1ps
module can_core_model (
  input  wire logic        i_clock,
  input  wire logic        i_tx_valid,
  input  wire logic        i_stall,
  input  wire logic [1:0]  i_delay,
  output logic             o_rx_valid,
  output logic             o_rx_long,
  output logic      [28:0] o_rx_id,
  output logic      [3:0]  o_rx_len,
  output logic      [63:0] o_rx_data,
  output logic             o_tx_won
);
  logic [1:0] wait_r;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_long  = 1'b0;
    o_rx_id    = 29'h0;
    o_rx_len   = 4'h0;
    o_rx_data  = 64'h0;
    o_tx_won   = 1'b0;
    wait_r     = 2'h0;
  end
  // Stall stands for arbitration lost to other nodes
  always @(posedge i_clock) begin
    o_tx_won <= 1'b0;
    if (i_tx_valid === 1'b1 && !o_tx_won && !i_stall) begin
      if (wait_r >= i_delay) begin
        o_tx_won <= 1'b1;
        wait_r   <= 2'h0;
      end else begin
        wait_r <= wait_r + 2'h1;
      end
    end
  end
  task automatic send(input logic l, input logic [28:0] id, input logic [3:0] n,
                      input logic [63:0] d);
    @(posedge i_clock);
    o_rx_valid <= 1'b1;
    o_rx_long  <= l;
    o_rx_id    <= id;
    o_rx_len   <= n;
    o_rx_data  <= d;
    @(posedge i_clock);
    o_rx_valid <= 1'b0;
    // Released id and data lines must not keep the last value
    o_rx_id    <= ~id;
    o_rx_data  <= ~d;
  endtask : send
endmodule : can_core_model

// *** tb/can_msg_buffer_tb.sv ***
// Self-checking bench for the CAN message buffer host port
`timescale 1ns/1ps
module can_msg_buffer_tb;
  logic        i_clock, i_rst, i_psel, i_penable, i_pwrite, i_rx_valid, i_rx_long, i_tx_won;
  logic        o_pready, o_pslverr, o_tx_valid, o_tx_long, o_ctrl_reset, o_irq, stall;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata, o_prdata, o_baud_rate, r1, r2;
  logic [28:0] i_rx_id, o_tx_id, rid;
  logic [3:0]  i_rx_len, o_tx_len;
  logic [63:0] i_rx_data, o_tx_data;
  logic [1:0]  delay;
  logic [32:0] rd_q[$];
  logic [33:0] tx_q[$];
  logic [33:0] tq;
  int          failures, tests_run, cyc, resets;
  can_msg_buffer can_msg_buffer_inst (
    .i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_rx_valid(i_rx_valid),
    .i_rx_long(i_rx_long), .i_rx_id(i_rx_id), .i_rx_len(i_rx_len), .i_rx_data(i_rx_data),
    .o_tx_valid(o_tx_valid), .o_tx_long(o_tx_long), .o_tx_id(o_tx_id), .o_tx_len(o_tx_len),
    .o_tx_data(o_tx_data), .i_tx_won(i_tx_won), .o_ctrl_reset(o_ctrl_reset),
    .o_baud_rate(o_baud_rate), .o_irq(o_irq));
  can_core_model can_core_model_inst (
    .i_clock(i_clock), .i_tx_valid(o_tx_valid), .i_stall(stall), .i_delay(delay),
    .o_rx_valid(i_rx_valid), .o_rx_long(i_rx_long), .o_rx_id(i_rx_id),
    .o_rx_len(i_rx_len), .o_rx_data(i_rx_data), .o_tx_won(i_tx_won));
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  // --------
  // Tasks
  // --------
  task automatic check(input string n, input logic [32:0] s, input logic [32:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  // Leading edge wait keeps back-to-back calls from double-driving psel
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_psel    <= 1'b1;
    i_pwrite  <= w;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do @(posedge i_clock); while (o_pready !== 1'b1);
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back({1'b0, e});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic cmd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    wr(a, d);
    rd(can_buf_pkg::OFF_RESULT, e);
  endtask : cmd
  // --------
  // Monitor
  // --------
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1)
      check("read", {o_pslverr, o_prdata}, rd_q.pop_front());
    if (o_tx_valid === 1'b1 && i_tx_won === 1'b1) begin
      tq = tx_q.pop_front();
      check("sent id", {o_tx_len, o_tx_id}, tq[32:0]);
      check("sent long", {32'h0, o_tx_long}, {32'h0, tq[33]});
      check("sent data lo", {1'b0, o_tx_data[31:0]}, 33'h2);
      check("sent data hi", {1'b0, o_tx_data[63:32]}, 33'h0);
    end
    if (o_ctrl_reset === 1'b1) resets++;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end
  // --------
  // Sequence
  // --------
  initial begin
    i_rst     = 1'b1;
    i_psel    = 1'b0;
    i_penable = 1'b0;
    i_pwrite  = 1'b0;
    i_paddr   = 8'h00;
    i_pwdata  = 32'h0;
    stall     = 1'b0;
    delay     = 2'h0;
    void'($urandom(13989));
    r1  = $urandom;
    r2  = $urandom;
    rid = 29'($urandom);
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    cmd(can_buf_pkg::OFF_FETCH, 32'h0, can_buf_pkg::RES_FAIL);
    wr(can_buf_pkg::OFF_ID, 32'h5);
    cmd(can_buf_pkg::OFF_TX, 32'h0, can_buf_pkg::RES_FAIL);
    rd_q.push_back({1'b1, 32'h0});
    apb(1'b0, 8'h50, 32'h0);
    $display("test pre-init done");
    cmd(can_buf_pkg::OFF_INIT, 32'h64, can_buf_pkg::RES_BAD);
    check("baud kept", o_baud_rate, can_buf_pkg::BAUD_RESET);
    cmd(can_buf_pkg::OFF_INIT, 32'hC350, can_buf_pkg::RES_OK);
    check("baud set", o_baud_rate, 32'hC350);
    $display("test init done");
    wr(can_buf_pkg::OFF_FLT_ID, 32'h28);
    cmd(can_buf_pkg::OFF_FLT_CTRL, 32'h4, can_buf_pkg::RES_OK);
    wr(can_buf_pkg::OFF_FLT_ID, 32'hBB8);
    cmd(can_buf_pkg::OFF_FLT_CTRL, 32'h5, can_buf_pkg::RES_BAD);
    wr(can_buf_pkg::OFF_FLT_ID, {3'h0, rid});
    cmd(can_buf_pkg::OFF_FLT_CTRL, 32'hD, can_buf_pkg::RES_OK);
    wr(can_buf_pkg::OFF_IRQ_MASK, 32'h1);
    check("irq idle", o_irq, 1'b0);
    can_core_model_inst.send(1'b0, 29'h28, 4'h3, {r2, r1});
    can_core_model_inst.send(1'b1, 29'h28, 4'h3, {r1, r2});
    can_core_model_inst.send(1'b1, rid, 4'h8, {r1, r2});
    repeat (3) @(posedge i_clock);
    check("irq rx", o_irq, 1'b1);
    cmd(can_buf_pkg::OFF_FETCH, 32'h0, 32'h28);
    rd(can_buf_pkg::OFF_LEN, 32'h3);
    rd(can_buf_pkg::OFF_DATA, {24'h0, r1[7:0]});
    cmd(can_buf_pkg::OFF_FETCH, 32'h0, {3'h0, rid});
    for (int k = 0; k < 8; k++)
      rd(can_buf_pkg::OFF_DATA + 8'(4 * k), {24'h0, 8'({r1, r2} >> (8 * k))});
    rd(can_buf_pkg::OFF_ID, {3'h0, rid});
    cmd(can_buf_pkg::OFF_FETCH, 32'h0, can_buf_pkg::RES_FAIL);
    wr(can_buf_pkg::OFF_IRQ_STAT, 32'h7);
    repeat (2) @(posedge i_clock);
    check("irq clear", o_irq, 1'b0);
    $display("test filter rx done");
    for (int i = 0; i < 66; i++)
      can_core_model_inst.send(1'b0, 29'h28, 4'h8, 64'(i));
    rd(can_buf_pkg::OFF_STATUS, 32'h1001);
    wr(can_buf_pkg::OFF_FETCH, 32'h0);
    rd(can_buf_pkg::OFF_DATA, 32'h2);
    $display("test overflow done");
    stall <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      wr(can_buf_pkg::OFF_ID, 32'h64 + i);
      cmd(can_buf_pkg::OFF_TX, 32'h0, i < 8 ? can_buf_pkg::RES_OK : can_buf_pkg::RES_FAIL);
    end
    wr(can_buf_pkg::OFF_ID, 32'hC8);
    cmd(can_buf_pkg::OFF_TX, 32'h3, can_buf_pkg::RES_OK);
    wr(can_buf_pkg::OFF_ID, 32'hC9);
    cmd(can_buf_pkg::OFF_TX, 32'h1, can_buf_pkg::RES_FAIL);
    tx_q.push_back({1'b1, 4'h8, 29'hC8});
    for (int i = 0; i < 8; i++) tx_q.push_back({1'b0, 4'h8, 29'(i + 32'h64)});
    delay <= 2'($urandom);
    stall <= 1'b0;
    while (tx_q.size() > 0) @(posedge i_clock);
    $display("test transmit done");
    stall <= 1'b1;
    wr(can_buf_pkg::OFF_ID, 32'h7);
    cmd(can_buf_pkg::OFF_TX, 32'h0, can_buf_pkg::RES_OK);
    cmd(can_buf_pkg::OFF_INIT, 32'hC350, can_buf_pkg::RES_OK);
    rd(can_buf_pkg::OFF_STATUS, 32'h1);
    check("ctrl resets", resets, 33'h3);
    can_core_model_inst.send(1'b0, 29'h28, 4'h1, 64'h0);
    cmd(can_buf_pkg::OFF_FETCH, 32'h0, can_buf_pkg::RES_FAIL);
    check("tx flushed", o_tx_valid, 1'b0);
    $display("test reinit done");
    conclude();
  end
endmodule : can_msg_buffer_tb
